//--- logic/servo_travel_torque_limit_defs.vh
/*
 * Constants for the servo travel and torque supervisor: setting ranges,
 * defaults and stop method codes.
 * Assumes inclusion by bare name from design files under logic/.
 */
`ifndef SERVO_TRAVEL_TORQUE_LIMIT_DEFS_VH
`define SERVO_TRAVEL_TORQUE_LIMIT_DEFS_VH

// ****************************************
// percentage settings
// ****************************************
`define PCT_W              9
`define PCT_MAX            9'h12C
`define INT_LIMIT_DEFAULT  9'h12C
`define EXT_LIMIT_DEFAULT  9'h064
`define PLUG_TORQUE_DEFAULT 9'h12C
`define MOTOR_MAX_DEFAULT  9'h12C

// ****************************************
// stop method codes
// ****************************************
`define STOP_W             3
`define STOP_DB            3'h0
`define STOP_COAST         3'h1
`define STOP_PLUG_OFF_DB   3'h2
`define STOP_PLUG_OFF_CST  3'h3
`define STOP_PLUG_ZC_DB    3'h4
`define STOP_PLUG_ZC_CST   3'h5

`endif

//--- logic/servo_travel_torque_limit.v
/*
 * Servo travel limit, stop method and torque limit supervisor.
 * Assumes all inputs but reset_n synchronous to clock; torque reference is an unsigned
 * percentage magnitude with direction bit; power_restart pulses high when power
 * is restored, and relatches only the direction setting.
 */
`timescale 1ns/100ps
`include "servo_travel_torque_limit_defs.vh"

//
// Contract
// - direction select 0 ccw forward, 1 cw
// - direction change applies only after power restart
// - forward limit high prohibits forward rotation only
// - reverse limit high prohibits reverse rotation only
// - forward usage 1 ignores forward limit input
// - reverse usage 1 ignores reverse limit input
// - overtravel keeps position error; host clears it
// - stop 0 dynamic brake then release, 1 coast
// - stop 2-5 plug brake on overtravel, zero clamp 4-5
// - plug braking torque limited by plug setting
// - servo off, alarm, power loss disable servo
// - internal limits per direction, default 300
// - external limits per direction, default 100
// - torque reaching active limit flags detection
// - limit above motor maximum uses motor maximum
// - external select input chooses external limit
// - limited output low while reference reaches or exceeds setting
module servo_travel_torque_limit #(
    parameter PCT_W = `PCT_W
) (
    input  wire             clock,                     // 20 MHz control clock
    input  wire             reset_n,                   // async reset, active low
    input  wire             power_restart,             // pulse: power restored, latch direction
    input  wire             rotation_direction_select, // 0 ccw forward, 1 cw forward
    input  wire             forward_travel_limit_in,   // low: forward allowed
    input  wire             reverse_travel_limit_in,   // low: reverse allowed
    input  wire             forward_limit_usage,       // 1 ignore forward limit input
    input  wire             reverse_limit_usage,       // 1 ignore reverse limit input
    input  wire [2:0]       stop_method_select,        // stop method 0..5
    input  wire [PCT_W-1:0] plug_brake_torque,         // plug braking torque percent
    input  wire [PCT_W-1:0] fwd_internal_torque_limit, // forward internal limit percent
    input  wire [PCT_W-1:0] rev_internal_torque_limit, // reverse internal limit percent
    input  wire [PCT_W-1:0] fwd_external_torque_limit, // forward external limit percent
    input  wire [PCT_W-1:0] rev_external_torque_limit, // reverse external limit percent
    input  wire [PCT_W-1:0] motor_max_torque,          // motor maximum torque percent
    input  wire             fwd_ext_limit_select_in,   // low: forward external limit
    input  wire             rev_ext_limit_select_in,   // low: reverse external limit
    input  wire             servo_on_in,               // 1 servo on requested
    input  wire             servo_alarm,               // 1 alarm active
    input  wire             power_ok,                  // 0 power lost
    input  wire             position_mode,             // 1 position control
    input  wire             error_clear_in,            // host clear of position error
    input  wire             torque_ref_neg,            // torque reference direction, 1 reverse
    input  wire [PCT_W-1:0] torque_ref_mag,            // torque reference magnitude percent
    output reg              direction_invert,          // active direction sense
    output reg              overtravel_condition,      // motor stopped by overtravel
    output reg              forward_inhibit,           // forward rotation prohibited
    output reg              reverse_inhibit,           // reverse rotation prohibited
    output reg              servo_enable,              // servo functions enabled
    output reg              dynamic_brake,             // dynamic brake applied
    output reg              plug_braking,              // plug braking active
    output reg              zero_clamp,                // zero clamp hold active
    output reg              hold_position_error,       // keep error count
    output reg              clear_position_error,      // discard error count
    output reg  [PCT_W-1:0] torque_limit_out,          // active torque limit
    output reg  [PCT_W-1:0] torque_cmd_out,            // clamped torque magnitude
    output reg              torque_cmd_neg,            // clamped torque direction
    output reg              torque_limited_out         // low: torque limited
);

    // ****************************************
    // direction setting latch
    // ****************************************
    reg dir_pending_q;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            direction_invert <= 1'b0;
            dir_pending_q    <= 1'b1;
        end else if (dir_pending_q || power_restart) begin
            direction_invert <= rotation_direction_select;
            dir_pending_q    <= 1'b0;
        end
    end

    // ****************************************
    // travel limits and stop decision
    // ****************************************
    wire fwd_block_d = !forward_limit_usage && forward_travel_limit_in;
    wire rev_block_d = !reverse_limit_usage && reverse_travel_limit_in;
    wire off_d       = !servo_on_in || servo_alarm || !power_ok;
    wire plug_mode   = (stop_method_select >= `STOP_PLUG_OFF_DB) &&
                       (stop_method_select <= `STOP_PLUG_ZC_CST);
    wire coast_mode  = stop_method_select[0];
    wire ot_d        = (fwd_block_d && !torque_ref_neg) || (rev_block_d && torque_ref_neg);

    reg plug_done_q;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            forward_inhibit      <= 1'b0;
            reverse_inhibit      <= 1'b0;
            overtravel_condition <= 1'b0;
            servo_enable         <= 1'b0;
            dynamic_brake        <= 1'b0;
            plug_braking         <= 1'b0;
            zero_clamp           <= 1'b0;
            plug_done_q          <= 1'b0;
            hold_position_error  <= 1'b0;
            clear_position_error <= 1'b0;
        end else begin
            forward_inhibit      <= fwd_block_d;
            reverse_inhibit      <= rev_block_d;
            overtravel_condition <= ot_d;
            clear_position_error <= error_clear_in;
            if (error_clear_in)
                hold_position_error <= 1'b0;
            else if (ot_d && position_mode)
                hold_position_error <= 1'b1;
            if (torque_ref_mag == {PCT_W{1'b0}} && plug_braking)
                plug_done_q <= 1'b1;
            else if (!ot_d)
                plug_done_q <= 1'b0;
            if (off_d) begin
                servo_enable  <= 1'b0;
                plug_braking  <= 1'b0;
                zero_clamp    <= 1'b0;
                dynamic_brake <= !coast_mode && (stop_method_select <= `STOP_PLUG_ZC_CST) &&
                                 (torque_ref_mag != {PCT_W{1'b0}});
            end else if (ot_d) begin
                if (plug_mode && !plug_done_q) begin
                    servo_enable  <= 1'b1;
                    plug_braking  <= 1'b1;
                    dynamic_brake <= 1'b0;
                end else if (plug_mode) begin
                    plug_braking  <= 1'b0;
                    zero_clamp    <= stop_method_select >= `STOP_PLUG_ZC_DB;
                    servo_enable  <= stop_method_select >= `STOP_PLUG_ZC_DB;
                    dynamic_brake <= 1'b0;
                end else begin
                    servo_enable  <= 1'b0;
                    dynamic_brake <= !coast_mode && (torque_ref_mag != {PCT_W{1'b0}});
                end
            end else begin
                servo_enable  <= 1'b1;
                dynamic_brake <= 1'b0;
                plug_braking  <= 1'b0;
                zero_clamp    <= 1'b0;
            end
        end
    end

    // ****************************************
    // torque limiting
    // ****************************************
    reg [PCT_W-1:0] sel_limit;
    reg [PCT_W-1:0] eff_limit;
    always @* begin
        if (torque_ref_neg)
            sel_limit = !rev_ext_limit_select_in ? rev_external_torque_limit : rev_internal_torque_limit;
        else
            sel_limit = !fwd_ext_limit_select_in ? fwd_external_torque_limit : fwd_internal_torque_limit;
        if (plug_braking && plug_brake_torque < sel_limit)
            sel_limit = plug_brake_torque;
        eff_limit = (sel_limit > motor_max_torque) ? motor_max_torque : sel_limit;
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            torque_limit_out   <= `INT_LIMIT_DEFAULT;
            torque_cmd_out     <= {PCT_W{1'b0}};
            torque_cmd_neg     <= 1'b0;
            torque_limited_out <= 1'b1;
        end else begin
            torque_limit_out   <= eff_limit;
            torque_cmd_neg     <= torque_ref_neg;
            torque_cmd_out     <= (torque_ref_mag > eff_limit) ? eff_limit : torque_ref_mag;
            torque_limited_out <= !(torque_ref_mag >= eff_limit);
        end
    end

endmodule

//--- verif/servo_travel_torque_limit_sva.sv
/* Checker on the servo supervisor top ports.
   Bound to every instance; one clock, async reset_n. */
`timescale 1ns/100ps
module servo_travel_torque_limit_sva #(parameter PCT_W = 9) (
    input wire             clock, reset_n, power_restart,                // clock, reset
    input wire             forward_travel_limit_in, forward_limit_usage, // forward limit
    input wire             reverse_travel_limit_in, reverse_limit_usage, // reverse limit
    input wire             servo_on_in, servo_alarm, power_ok,           // servo-off causes
    input wire [2:0]       stop_method_select,                           // stop method
    input wire [PCT_W-1:0] plug_brake_torque, motor_max_torque,          // settings
    input wire             direction_invert, forward_inhibit, reverse_inhibit, // travel
    input wire             servo_enable, dynamic_brake, plug_braking,    // stop state
    input wire [PCT_W-1:0] torque_limit_out, torque_cmd_out              // torque
);
    reg [1:0] up_q;  // two edges past reset release
    wire      up = up_q[1];
    always @(posedge clock or negedge reset_n) up_q <= reset_n ? {up_q[0], 1'b1} : 2'h0;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_FWD_STOP: assert property (up && forward_travel_limit_in && !forward_limit_usage |=> forward_inhibit)
        else $error("forward not inhibited");
    AST_FWD_FREE: assert property (up && forward_limit_usage |=> !forward_inhibit)
        else $error("forward limit not ignored");
    AST_REV_STOP: assert property (up && reverse_travel_limit_in && !reverse_limit_usage |=> reverse_inhibit)
        else $error("reverse not inhibited");
    AST_SERVO_OFF: assert property (up && (!servo_on_in || servo_alarm || !power_ok) |=> !servo_enable)
        else $error("servo left on");
    AST_DIR_HOLD: assert property (up && !power_restart && !$past(power_restart) |=> $stable(direction_invert))
        else $error("direction moved");
    AST_PLUG_CAP: assert property (up && $past(plug_braking) |-> torque_limit_out <= $past(plug_brake_torque))
        else $error("plug torque exceeded");
    AST_MAX_CAP: assert property (up |-> torque_limit_out <= $past(motor_max_torque))
        else $error("motor maximum exceeded");
    AST_CLAMP: assert property (torque_cmd_out <= torque_limit_out)
        else $error("torque not clamped");
    AST_DB_EVEN: assert property (up && dynamic_brake |-> !$past(stop_method_select[0]))
        else $error("brake while coasting");
    cover property (plug_braking);
    cover property (dynamic_brake);
    cover property (up && $fell(servo_enable));
endmodule
bind servo_travel_torque_limit servo_travel_torque_limit_sva #(.PCT_W(PCT_W)) servo_travel_torque_limit_sva_inst (.*);

//--- verif/limit_switch_model.sv
/* Limit switches: contact opens (line high) while the axis sits on a limit.
   Requests come from tb, synchronous to clock. */
`timescale 1ns/100ps
module limit_switch_model (
    input  wire clock,                       // control clock
    input  wire fwd_hit,                     // axis at forward end
    input  wire rev_hit,                     // axis at reverse end
    output reg  forward_travel_limit_in = 0, // high: open
    output reg  reverse_travel_limit_in = 0  // high: open
);
    always @(posedge clock) {forward_travel_limit_in, reverse_travel_limit_in} <= {fwd_hit, rev_hit};
endmodule

//--- verif/tb.sv
/* Testbench: direction, overtravel, stop methods, torque clamp.
   Limit switch lines come from limit_switch_model. */
`timescale 1ns/100ps
module tb;
    logic       clock = 0, reset_n = 0, power_restart = 0, rotation_direction_select = 1, fwd_hit = 0, rev_hit = 0;
    logic       forward_limit_usage = 0, reverse_limit_usage = 0, fwd_ext_limit_select_in = 1, rev_ext_limit_select_in = 1;
    logic       servo_on_in = 1, servo_alarm = 0, power_ok = 1, position_mode = 1, error_clear_in = 0, torque_ref_neg = 0;
    logic [2:0] stop_method_select = 0;
    logic [8:0] plug_brake_torque = 9'h046, fwd_internal_torque_limit = 9'h12C, rev_internal_torque_limit = 9'h12C;
    logic [8:0] fwd_external_torque_limit = 9'h064, rev_external_torque_limit = 9'h064, motor_max_torque = 9'h12C;
    logic [8:0] torque_ref_mag = 9'h000;
    wire        forward_travel_limit_in, reverse_travel_limit_in, direction_invert, overtravel_condition, forward_inhibit;
    wire        reverse_inhibit, servo_enable, dynamic_brake, plug_braking, zero_clamp, hold_position_error;
    wire        clear_position_error, torque_cmd_neg, torque_limited_out;
    wire [8:0]  torque_limit_out, torque_cmd_out;
    int         n_errors = 0, n_compared = 0, cycles = 0;
    servo_travel_torque_limit servo_travel_torque_limit_inst (.*);
    limit_switch_model limit_switch_model_inst (.*);
    task automatic summarize(input int extra);
        n_errors += extra;
        if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, exp);
        n_compared++;
        n_errors += int'(got !== exp);
        if (got !== exp) $display("Error at %0t: got %h, expected %h", $time, got, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic row(input logic [2:0] sel, input logic [8:0] fi, fe, ri, re, mx, mag, lim);
        @(posedge clock);
        {torque_ref_neg, fwd_ext_limit_select_in, rev_ext_limit_select_in, torque_ref_mag} <= {sel, mag};
        {fwd_internal_torque_limit, fwd_external_torque_limit, rev_internal_torque_limit} <= {fi, fe, ri};
        {rev_external_torque_limit, motor_max_torque} <= {re, mx};
        tick(3);
        chk({torque_limit_out, torque_cmd_out}, {lim, mag < lim ? mag : lim});
        chk(torque_limited_out, mag < lim);
        chk(torque_cmd_neg, sel[2]);
    endtask
    initial forever #25 clock = ~clock;
    always @(posedge clock) if (++cycles == 3000) summarize(1);
    initial begin
        tick(19);
        @(posedge clock) reset_n <= 1;
        tick(3);
        chk(direction_invert, 1);
        @(posedge clock) rotation_direction_select <= 0;
        tick(3);
        chk(direction_invert, 1);
        @(posedge clock) power_restart <= 1;
        @(posedge clock) power_restart <= 0;
        tick(3);
        chk(direction_invert, 0);
        row(3'h3, 9'h096, 9'h064, 9'h12C, 9'h064, 9'h12C, 9'h096, 9'h096);
        row(3'h1, 9'h096, 9'h064, 9'h12C, 9'h064, 9'h12C, 9'h096, 9'h064);
        row(3'h7, 9'h12C, 9'h064, 9'h028, 9'h064, 9'h12C, 9'h03C, 9'h028);
        row(3'h6, 9'h12C, 9'h064, 9'h028, 9'h0FA, 9'h0C8, 9'h03C, 9'h0C8);
        for (int m = 0; m < 6; m++) begin
            @(posedge clock) {stop_method_select, torque_ref_neg, torque_ref_mag, fwd_hit} <= {m[2:0], 11'h0C9};
            tick(3);
            chk({forward_inhibit, reverse_inhibit, overtravel_condition, hold_position_error}, 4'hB);
            chk({plug_braking, dynamic_brake}, {m > 1, m == 0});
            if (m > 1) chk(torque_limit_out, 9'h046);
            @(posedge clock) {torque_ref_mag, error_clear_in} <= 10'h001;
            tick(4);
            chk({plug_braking, zero_clamp, hold_position_error, clear_position_error}, {1'b0, m > 3, 2'h1});
            chk({servo_enable, dynamic_brake}, {m > 3, 1'b0});
            @(posedge clock) {fwd_hit, error_clear_in} <= 2'h0;
            tick(4);
        end
        @(posedge clock) {forward_limit_usage, fwd_hit, rev_hit} <= 3'h7;
        tick(3);
        chk({forward_inhibit, reverse_inhibit}, 2'h1);
        @(posedge clock) {reverse_limit_usage, servo_on_in, stop_method_select, torque_ref_mag} <= {2'h2, 12'h064};
        tick(3);
        chk({reverse_inhibit, servo_enable, dynamic_brake}, 3'h1);
        summarize(0);
    end
endmodule
